/* rtl/sgpr_consts.svh */
// constants for the shadow register file block
`ifndef SGPR_CONSTS_SVH
`define SGPR_CONSTS_SVH
`define SGPR_XLEN 32
`define SGPR_NREG 32
`define SGPR_IDXW 5
`define SGPR_SETW 4
`define SGPR_NSETS 4
`define SGPR_HIGH_SET 4'h3
`define SGPR_NVEC 8
`define SGPR_VECW 3
`define SGPR_MAPW 32
`define SGPR_ZERO_IDX 5'h00
`define SGPR_ZERO_SET 4'h0
`define SGPR_ZERO_WORD 32'h00000000
// register offsets on the software port
`define SGPR_OFS_SETCTL 4'h0
`define SGPR_OFS_MAP 4'h1
`define SGPR_OFS_CFG3 4'h2
`define SGPR_OFS_IMODE 4'h3
// set control field positions
`define SGPR_HIGH_LSB 26
`define SGPR_EXCSEL_LSB 12
`define SGPR_PREV_LSB 6
`define SGPR_CUR_LSB 0
// third config bit positions
`define SGPR_VECPRES_BIT 5
`define SGPR_XPRES_BIT 6
// interrupt mode encodings
`define SGPR_MODE_COMPAT 2'h0
`define SGPR_MODE_VEC 2'h1
`define SGPR_MODE_EXT 2'h2
`endif

/* rtl/sgpr_pkg.sv */
// types for the shadow register file block
package sgpr_pkg;
  typedef logic [31:0] sgpr_word_t;
  typedef logic [3:0] sgpr_set_t;
  typedef logic [4:0] sgpr_idx_t;
  typedef struct packed {
    sgpr_word_t [15:0] [31:0] regs;
    sgpr_set_t cur_sel;
    sgpr_set_t prev_sel;
    sgpr_set_t exc_sel;
    logic [31:0] map;
    logic [1:0] imode;
    logic xp_s1;
    logic xp_s2;
    logic xp_s3;
    logic xp_present;
    sgpr_word_t rd_a;
    sgpr_word_t rd_b;
    sgpr_word_t sw_rdata;
    sgpr_set_t cur_sel_out;
  } sgpr_state_t;
  typedef struct packed {
    logic en;
    sgpr_set_t set;
    sgpr_idx_t idx;
    sgpr_word_t data;
  } sgpr_wr_t;
endpackage : sgpr_pkg

/* rtl/sgpr_file.sv */
// shadow register file with set selection control
// Functional notes
// RL1 - base bank of thirty-two 32-bit general registers
// RL2 - two read ports, one write port, write forwarded to reads
// RL3 - set count fixed at build time: 1, 2, 4, 8 or 16
// RL4 - base bank is set number zero
// RL5 - read-only highest set field shows top implemented set, zero if one
// RL6 - ordinary references steered to the current set
// RL7 - cross-set read and write reach registers of any set
// RL8 - current set field holds set in use
// RL9 - previous set field holds set current before last exception
// RL10 - vectored mode entry set comes from vector-to-set map
// RL11 - external controller mode uses the set number it supplies
// RL12 - exceptions and non-vectored interrupts use exception set field
// RL13 - on entry copy current to previous, then load current from source
// RL14 - exception return copies previous back into current
// RL15 - vectored mode present bit always reads one
// RL16 - external controller present bit mirrors a static system input
// RL17 - reset leaves block in compatibility interrupt mode
// RL18 - register zero reads zero; forwarding matches index and set
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "sgpr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sgpr_file (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // read ports, data one cycle later
  input wire logic [4:0] RA_IDX,
  input wire logic [4:0] RB_IDX,
  input wire logic RA_XSET,
  input wire logic [3:0] RA_SET,
  output logic [31:0] RA_DATA,
  output logic [31:0] RB_DATA,
  // write port
  input wire logic WR_EN,
  input wire logic WR_XSET,
  input wire logic [3:0] WR_SET,
  input wire logic [4:0] WR_IDX,
  input wire logic [31:0] WR_DATA,
  // exception and interrupt events
  input wire logic EXC_TAKE,
  input wire logic EXC_IS_VEC_INT,
  input wire logic [2:0] EXC_VEC_NUM,
  input wire logic [3:0] EXT_SET,
  input wire logic XRET_DO,
  input wire logic EXT_CTRL_PRESENT_IN,
  // software register port
  input wire logic [3:0] SW_ADDR,
  input wire logic [31:0] SW_WDATA,
  input wire logic SW_WR,
  input wire logic SW_RD,
  output logic [31:0] SW_RDATA,
  // current set shown to the pipeline
  output logic [3:0] CUR_SET
);

  sgpr_pkg::sgpr_state_t s_reg;
  sgpr_pkg::sgpr_state_t s_next;
  sgpr_pkg::sgpr_set_t ra_set_eff;
  sgpr_pkg::sgpr_set_t wr_set_eff;
  sgpr_pkg::sgpr_set_t entry_set;
  sgpr_pkg::sgpr_word_t setctl_word;
  sgpr_pkg::sgpr_word_t cfg3_word;
  logic wr_ok;

  // set steering: ordinary refs use current set, cross-set uses given one
  always_comb begin
    ra_set_eff = RA_XSET ? RA_SET : s_reg.cur_sel; // RL6 RL7
    wr_set_eff = WR_XSET ? WR_SET : s_reg.cur_sel; // RL6 RL7
    // writes to register zero or a missing set are dropped
    wr_ok = WR_EN && (WR_IDX != `SGPR_ZERO_IDX) &&
      (wr_set_eff <= `SGPR_HIGH_SET); // RL18 RL3
  end

  // entry set source follows interrupt mode
  always_comb begin
    entry_set = s_reg.exc_sel; // RL12
    if (EXC_IS_VEC_INT && s_reg.imode == `SGPR_MODE_VEC) begin
      entry_set = s_reg.map[{EXC_VEC_NUM, 2'h0} +: `SGPR_SETW]; // RL10
    end else if (EXC_IS_VEC_INT && s_reg.imode == `SGPR_MODE_EXT) begin
      entry_set = EXT_SET; // RL11
    end
    // clamp so an unimplemented set is never selected
    if (entry_set > `SGPR_HIGH_SET) begin
      entry_set = `SGPR_ZERO_SET;
    end
  end

  // readable views of the control registers
  always_comb begin
    setctl_word = `SGPR_ZERO_WORD;
    setctl_word[`SGPR_HIGH_LSB +: `SGPR_SETW] = `SGPR_HIGH_SET; // RL5
    setctl_word[`SGPR_EXCSEL_LSB +: `SGPR_SETW] = s_reg.exc_sel;
    setctl_word[`SGPR_PREV_LSB +: `SGPR_SETW] = s_reg.prev_sel; // RL9
    setctl_word[`SGPR_CUR_LSB +: `SGPR_SETW] = s_reg.cur_sel; // RL8
    cfg3_word = `SGPR_ZERO_WORD;
    cfg3_word[`SGPR_VECPRES_BIT] = 1'b1; // RL15
    cfg3_word[`SGPR_XPRES_BIT] = s_reg.xp_present; // RL16
  end

  // next state
  always_comb begin
    s_next = s_reg;
    // strap input through three flops, accepted when last two agree
    s_next.xp_s1 = EXT_CTRL_PRESENT_IN;
    s_next.xp_s2 = s_reg.xp_s1;
    s_next.xp_s3 = s_reg.xp_s2;
    if (s_reg.xp_s2 == s_reg.xp_s3) begin
      s_next.xp_present = s_reg.xp_s3; // RL16
    end
    // storage write; base bank is set zero
    if (wr_ok) begin
      s_next.regs[wr_set_eff][WR_IDX] = WR_DATA; // RL1 RL4 RL3
    end
    // read with full forwarding of the same-cycle write
    s_next.rd_a = s_reg.regs[ra_set_eff][RA_IDX];
    if (wr_ok && WR_IDX == RA_IDX && wr_set_eff == ra_set_eff) begin
      s_next.rd_a = WR_DATA; // RL2 RL18
    end
    if (RA_IDX == `SGPR_ZERO_IDX || ra_set_eff > `SGPR_HIGH_SET) begin
      s_next.rd_a = `SGPR_ZERO_WORD; // RL18
    end
    s_next.rd_b = s_reg.regs[s_reg.cur_sel][RB_IDX];
    if (wr_ok && WR_IDX == RB_IDX && wr_set_eff == s_reg.cur_sel) begin
      s_next.rd_b = WR_DATA; // RL2 RL18
    end
    if (RB_IDX == `SGPR_ZERO_IDX) begin
      s_next.rd_b = `SGPR_ZERO_WORD; // RL18
    end
    // software writes; events below take priority over the set fields
    if (SW_WR) begin
      case (SW_ADDR)
        `SGPR_OFS_SETCTL: begin
          if (SW_WDATA[`SGPR_EXCSEL_LSB +: `SGPR_SETW] <= `SGPR_HIGH_SET)
          begin
            s_next.exc_sel = SW_WDATA[`SGPR_EXCSEL_LSB +: `SGPR_SETW]; // RL12
          end
          if (SW_WDATA[`SGPR_PREV_LSB +: `SGPR_SETW] <= `SGPR_HIGH_SET) begin
            s_next.prev_sel = SW_WDATA[`SGPR_PREV_LSB +: `SGPR_SETW];
          end
        end
        `SGPR_OFS_MAP: s_next.map = SW_WDATA; // RL10
        `SGPR_OFS_IMODE: begin
          if (SW_WDATA[1:0] == `SGPR_MODE_EXT && !s_reg.xp_present) begin
            s_next.imode = `SGPR_MODE_COMPAT;
          end else if (SW_WDATA[1:0] <= `SGPR_MODE_EXT) begin
            s_next.imode = SW_WDATA[1:0];
          end
        end
        default: s_next.imode = s_next.imode;
      endcase
    end
    // entry wins over return when both arrive
    if (EXC_TAKE) begin
      s_next.prev_sel = s_reg.cur_sel; // RL13
      s_next.cur_sel = entry_set; // RL13
    end else if (XRET_DO) begin
      s_next.cur_sel = s_reg.prev_sel; // RL14
    end
    s_next.cur_sel_out = s_next.cur_sel;
    // software read data, valid the cycle after the strobe only
    s_next.sw_rdata = `SGPR_ZERO_WORD;
    if (SW_RD) begin
      case (SW_ADDR)
        `SGPR_OFS_SETCTL: s_next.sw_rdata = setctl_word;
        `SGPR_OFS_MAP: s_next.sw_rdata = s_reg.map;
        `SGPR_OFS_CFG3: s_next.sw_rdata = cfg3_word;
        `SGPR_OFS_IMODE: s_next.sw_rdata = {30'h00000000, s_reg.imode};
        default: s_next.sw_rdata = `SGPR_ZERO_WORD;
      endcase
    end
  end

  // one register for all state; resets to compatibility mode, set zero
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_reg <= '0; // RL17
    end else begin
      s_reg <= s_next;
    end
  end

  assign RA_DATA = s_reg.rd_a;
  assign RB_DATA = s_reg.rd_b;
  assign SW_RDATA = s_reg.sw_rdata;
  assign CUR_SET = s_reg.cur_sel_out;

  // checks
  property p_entry_prev;
    @(posedge CLK_SYS) disable iff (RST)
      EXC_TAKE |=> (s_reg.prev_sel == $past(s_reg.cur_sel));
  endproperty
  a_entry_prev: assert property (p_entry_prev) // RL13
    else $error("previous set not saved on entry");

  property p_xret;
    @(posedge CLK_SYS) disable iff (RST)
      (XRET_DO && !EXC_TAKE) |=> (s_reg.cur_sel == $past(s_reg.prev_sel));
  endproperty
  a_xret: assert property (p_xret) // RL14
    else $error("return did not restore current set");

  property p_exc_set;
    @(posedge CLK_SYS) disable iff (RST)
      (EXC_TAKE && !EXC_IS_VEC_INT) |=>
      (s_reg.cur_sel == $past(s_reg.exc_sel));
  endproperty
  a_exc_set: assert property (p_exc_set) // RL12
    else $error("exception did not use exception set");

  property p_ext;
    @(posedge CLK_SYS) disable iff (RST)
      (EXC_TAKE && EXC_IS_VEC_INT && s_reg.imode == `SGPR_MODE_EXT &&
       EXT_SET <= `SGPR_HIGH_SET) |=> (s_reg.cur_sel == $past(EXT_SET));
  endproperty
  a_ext: assert property (p_ext) // RL11
    else $error("external set not used");

  property p_zero;
    @(posedge CLK_SYS) disable iff (RST)
      (RA_IDX == `SGPR_ZERO_IDX) |=> (RA_DATA == `SGPR_ZERO_WORD);
  endproperty
  a_zero: assert property (p_zero) // RL18
    else $error("register zero not zero");

  property p_fwd;
    @(posedge CLK_SYS) disable iff (RST)
      (wr_ok && WR_IDX == RB_IDX && wr_set_eff == s_reg.cur_sel)
      |=> (RB_DATA == $past(WR_DATA));
  endproperty
  a_fwd: assert property (p_fwd) // RL2
    else $error("write not forwarded");

  property p_vectored_mode_present_bit;
    @(posedge CLK_SYS) disable iff (RST)
      (SW_RD && SW_ADDR == `SGPR_OFS_CFG3) |=> SW_RDATA[`SGPR_VECPRES_BIT];
  endproperty
  a_vectored_mode_present_bit: assert property (p_vectored_mode_present_bit) // RL15
    else $error("vectored present bit not one");

  property p_high_set;
    @(posedge CLK_SYS) disable iff (RST)
      (SW_RD && SW_ADDR == `SGPR_OFS_SETCTL)
      |=> (SW_RDATA[`SGPR_HIGH_LSB +: `SGPR_SETW] == `SGPR_HIGH_SET);
  endproperty
  a_high_set: assert property (p_high_set) // RL5
    else $error("highest set field wrong");

  property p_cur_out;
    @(posedge CLK_SYS) disable iff (RST)
      CUR_SET == s_reg.cur_sel;
  endproperty
  a_cur_out: assert property (p_cur_out) // RL8
    else $error("current set output stale");

endmodule // sgpr_file
`default_nettype wire

/* test/sgpr_eic_model.sv */
// external interrupt controller model: set per vector and presence strap
`timescale 1ns/1ps
`default_nettype none
module sgpr_xctl_model (
  // vector being raised
  input wire logic [2:0] vec_num,
  // set offered and strap
  output logic [3:0] ext_set,
  output logic present
);
  // set derived from the vector, kept inside the four built sets
  assign ext_set = {2'h0, ~vec_num[1:0]};
  // strap never moves, so the presence bit cannot flicker
  assign present = 1'h1;
endmodule // sgpr_xctl_model
`default_nettype wire

/* test/sgpr_file_tb_top.sv */
// self-checking bench for the shadow register file
`timescale 1ns/1ps
`default_nettype none
module sgpr_file_tb_top;
  logic clk = 1'h0, rst = 1'h1;
  logic [4:0] ra_idx = 5'h00, rb_idx = 5'h00, wr_idx = 5'h00;
  logic ra_xset = 1'h0, wr_en = 1'h0, wr_xset = 1'h0;
  logic [3:0] ra_set = 4'h0, wr_set = 4'h0, ext_set, cur_set, sw_addr = 4'h0;
  logic [31:0] ra_data, rb_data, wr_data = 32'h0, sw_wdata = 32'h0, sw_rdata;
  logic exc_take = 1'h0, exc_vec = 1'h0, xret = 1'h0, sw_wr = 1'h0;
  logic sw_rd = 1'h0, strap;
  logic [2:0] vec_num = 3'h0;
  int miscompares = 0, comparisons = 0, cycles = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  sgpr_file sgpr_file_i (.CLK_SYS(clk), .RST(rst), .RA_IDX(ra_idx),
    .RB_IDX(rb_idx), .RA_XSET(ra_xset), .RA_SET(ra_set), .RA_DATA(ra_data),
    .RB_DATA(rb_data), .WR_EN(wr_en), .WR_XSET(wr_xset), .WR_SET(wr_set),
    .WR_IDX(wr_idx), .WR_DATA(wr_data), .EXC_TAKE(exc_take),
    .EXC_IS_VEC_INT(exc_vec), .EXC_VEC_NUM(vec_num), .EXT_SET(ext_set),
    .XRET_DO(xret), .EXT_CTRL_PRESENT_IN(strap), .SW_ADDR(sw_addr),
    .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata),
    .CUR_SET(cur_set));
  sgpr_xctl_model sgpr_xctl_model_i (.vec_num(vec_num), .ext_set(ext_set),
    .present(strap));
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard, the whole sequence needs about 85 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_wr <= 1'h1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe is taken
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_rd <= 1'h1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'h0;
    #1 d = sw_rdata;
  endtask
  // one pipeline cycle: optional write plus both reads, data one cycle on
  task automatic pipe(input logic we, xw, input logic [3:0] ws,
    input logic [4:0] wi, input logic [31:0] wd, input logic xr,
    input logic [3:0] rs, input logic [4:0] ia, ib);
    @(posedge clk);
    {wr_en, wr_xset, wr_set, wr_idx, wr_data} <= {we, xw, ws, wi, wd};
    {ra_xset, ra_set, ra_idx, rb_idx} <= {xr, rs, ia, ib};
    @(posedge clk);
    wr_en <= 1'h0;
    #1;
  endtask
  // entry or return event, current set checked once it lands
  task automatic event_do(input logic tk, vi, input logic [2:0] vn,
    input logic er);
    @(posedge clk);
    {exc_take, exc_vec, vec_num, xret} <= {tk, vi, vn, er};
    @(posedge clk);
    {exc_take, xret} <= 2'h0;
    #1;
  endtask
  logic [31:0] d;
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    sw_read(4'h0, d); check("setctl reset", d, 32'h0c000000);
    sw_read(4'h2, d); check("cfg3", d, 32'h00000060);
    check("ext present", d[6], 1'h1);
    sw_read(4'h3, d); check("imode reset", d, 32'h0);
    sw_read(4'hf, d); check("unmapped", d, 32'h0);
    sw_write(4'h2, 32'h0); sw_read(4'h2, d);
    check("cfg3 ro", d, 32'h60);
    // write forwarded to both ports in the same cycle
    pipe(1, 0, 0, 5'h05, 32'ha5a5a5a5, 0, 0, 5'h05, 5'h05);
    check("bypass a", ra_data, 32'ha5a5a5a5);
    check("bypass b", rb_data, 32'ha5a5a5a5);
    pipe(1, 0, 0, 5'h00, 32'hffffffff, 0, 0, 5'h00, 5'h00);
    check("r0 fwd", rb_data, 32'h0);
    pipe(0, 0, 0, 5'h00, 32'h0, 0, 0, 5'h00, 5'h1f);
    check("r0 read", ra_data, 32'h0);
    check("r31 zero", rb_data, 32'h0);
    // cross-set write may not forward into a current-set reader
    pipe(1, 1, 2, 5'h05, 32'h12345678, 0, 0, 5'h05, 5'h05);
    check("set mismatch fwd", rb_data, 32'ha5a5a5a5);
    pipe(0, 0, 0, 5'h00, 32'h0, 1, 2, 5'h05, 5'h05);
    check("xset read", ra_data, 32'h12345678);
    check("base bank", rb_data, 32'ha5a5a5a5);
    // compatibility mode entry uses the exception set field
    sw_write(4'h0, 32'h0000200f);
    event_do(1, 1, 3'h3, 0); check("compat entry", cur_set, 4'h2);
    pipe(0, 0, 0, 5'h00, 32'h0, 0, 0, 5'h05, 5'h05);
    check("steered read", rb_data, 32'h12345678);
    sw_read(4'h0, d); check("setctl entry", d, 32'h0c002002);
    event_do(0, 0, 3'h0, 1); check("return", cur_set, 4'h0);
    // vectored mode takes the map nibble, then a nested exception
    sw_write(4'h3, 32'h1); sw_write(4'h1, 32'h00001000);
    sw_read(4'h1, d); check("map", d, 32'h00001000);
    event_do(1, 1, 3'h3, 0); check("vec entry", cur_set, 4'h1);
    event_do(1, 0, 3'h0, 0); check("nested", cur_set, 4'h2);
    sw_read(4'h0, d); check("setctl nested", d, 32'h0c002042);
    event_do(0, 0, 3'h0, 1); check("return nested", cur_set, 4'h1);
    // vector 1 maps to set 0; a return instead would give set 1
    event_do(1, 1, 3'h1, 1); check("take beats return", cur_set, 4'h0);
    sw_read(4'h0, d); check("prev after", d[9:6], 4'h1);
    // software clears the previous set so the return lands on base
    sw_write(4'h0, 32'h00002000);
    event_do(0, 0, 3'h0, 1); check("back to base", cur_set, 4'h0);
    // external controller mode uses the set it offers
    sw_write(4'h3, 32'h2); sw_read(4'h3, d);
    check("ext mode", d, 32'h2);
    event_do(1, 1, 3'h1, 0); check("ext entry", cur_set, 4'h2);
    event_do(1, 1, 3'h3, 0); check("ext entry 2", cur_set, 4'h0);
    sw_write(4'h3, 32'h3); sw_read(4'h3, d);
    check("mode 3 dropped", d, 32'h2);
    conclude();
  end
endmodule // sgpr_file_tb_top
`default_nettype wire
